// File: rtl/rsr_pkg.sv
// Constants and types shared by the reset and stop-recovery controller
package rsr_pkg;
   localparam int ADDR_W = 12;
   // Register byte offsets
   localparam logic [11:0] OFF_INT_STAT = 12'h000;
   localparam logic [11:0] OFF_INT_MASK = 12'h004;
   localparam logic [11:0] OFF_RECOV_EN = 12'h008;
   localparam logic [11:0] OFF_DBGCTL   = 12'h00C;
   localparam logic [11:0] OFF_WDCTL    = 12'hFF0;
   // Cause flags in the watchdog control register
   localparam int WDCTL_POR  = 7;
   localparam int WDCTL_STOP = 6;
   localparam int WDCTL_WDT  = 5;
   localparam int WDCTL_EXT  = 4;
   localparam logic [7:0] WDCTL_RST      = 8'h00;
   localparam logic [7:0] WDCTL_POR_INIT = 8'h80;
   // Debugger control: reset command bit
   localparam int DBG_RST_BIT = 1;
   // Interrupt status and mask layout
   localparam int INT_W        = 3;
   localparam int INT_RELEASE  = 0;
   localparam int INT_RECOVERY = 1;
   localparam int INT_WDT_STOP = 2;
   // Synchroniser bit positions
   localparam int SY_POR  = 0;
   localparam int SY_BO   = 1;
   localparam int SY_WDT  = 2;
   localparam int SY_PIN  = 3;
   localparam int SY_DBG  = 4;
   localparam int SY_PORT = 5;
   // Hold counts
   localparam int CNT_W        = 10;
   localparam int WD_LONG_CNT  = 514;
   localparam int WD_SHORT_CNT = 66;
   localparam int SYS_CNT      = 16;
   localparam logic [15:0] RESET_VEC_ADDR = 16'h0002;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      KIND_SYSTEM  = 2'h0,
      KIND_SHORT   = 2'h1,
      KIND_RECOVER = 2'h2,
      KIND_DEBUG   = 2'h3
   } rsr_kind_type;

   typedef enum logic [1:0] {
      ST_HOLD    = 2'h1,
      ST_FETCH   = 2'h3,
      ST_RUN     = 2'h2,
      ST_PINWAIT = 2'h0
   } rsr_state_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_WD   = 2'h1,
      PH_SYS  = 2'h3,
      PH_DONE = 2'h2
   } rsr_phase_type;
endpackage

// File: rtl/rsr_hold_cnt.sv
// Two-phase hold counter: oscillator ticks, then system clocks
`timescale 1ns/1ps
`default_nettype none
module rsr_hold_cnt import rsr_pkg::*; #(
   parameter int WD_LONG  = WD_LONG_CNT,
   parameter int WD_SHORT = WD_SHORT_CNT,
   parameter int SYS_CYC  = SYS_CNT
) (
   // Clock and control
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Sequence control
   input  wire logic start,
   input  wire logic short_sel,
   input  wire logic wd_tick,
   // Status
   output logic      wd_expired,
   output logic      done
);
   typedef struct packed {
      rsr_phase_type    phase;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] ticks;
      logic             short_q;
      logic             done;
   } rsr_cnt_type;

   rsr_cnt_type s;
   rsr_cnt_type n;

   always_comb begin
      n = s;
      n.done = 1'b0;
      case (s.phase)
         PH_WD: begin
            if (wd_tick) begin
               n.ticks = s.ticks + 1'b1;
               if (s.cnt == CNT_W'(1)) begin
                  n.phase = PH_SYS;
                  n.cnt   = CNT_W'(SYS_CYC);
               end else begin
                  n.cnt = s.cnt - 1'b1;
               end
            end
         end
         PH_SYS: begin
            if (s.cnt == CNT_W'(1)) begin
               n.phase = PH_DONE;
               n.done  = 1'b1;
            end else begin
               n.cnt = s.cnt - 1'b1;
            end
         end
         default: begin
         end
      endcase
      if (start) begin
         n.phase   = PH_WD;
         n.cnt     = short_sel ? CNT_W'(WD_SHORT) : CNT_W'(WD_LONG);
         n.ticks   = '0;
         n.short_q = short_sel;
         n.done    = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s       <= '0;
         s.phase <= PH_WD;
         s.cnt   <= CNT_W'(WD_LONG);
      end else if (ce) begin
         s <= n;
      end
   end

   assign wd_expired = (s.phase == PH_SYS) || (s.phase == PH_DONE);
   assign done       = s.done;

   sequence sys_entry;
      $rose(s.phase == PH_SYS);
   endsequence

   a_wd_tick_count: assert property (@(posedge clk) disable iff (rst || !ce)
      sys_entry |-> s.ticks == (s.short_q ? CNT_W'(WD_SHORT) : CNT_W'(WD_LONG)))
      else $error("oscillator hold count wrong");
   a_sys_sixteen: assert property (@(posedge clk) disable iff (rst || !ce || start)
      sys_entry |-> !s.done [*8] ##1 !s.done [*8] ##1 s.done)
      else $error("system clock hold not sixteen cycles");
endmodule
`default_nettype wire

// File: rtl/rsr_reset_ctrl.sv
// Reset and stop-mode recovery controller with AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reset from power-on, brown-out, watchdog, reset pin, debugger command.
// - Watchdog time-out outside stop resets only when the reset option selects reset.
// - In stop, watchdog, enabled port change or debug pin low wakes device.
// - Reset type follows both operating mode and request source.
// - System reset holds 514 oscillator ticks then 16 system clocks.
// - Short reset holds 66 oscillator ticks then 16 system clocks.
// - Stop recovery resets core, 514 plus 16, registers kept except cause.
// - During hold core and peripherals idle, oscillators keep running.
// - System clock starts after oscillator count; 16 more idle cycles.
// - System or short reset loads register defaults and resets core.
// - After release the core fetches the vector at 0002H and 0003H.
// - Mode and source pick system, short, or debugger-sparing reset.
// - Power-on, and brown-out outside stop, win over every other source.
// - Reset pin low holds reset; release exits at once after oscillator count.
// - Cause flags power-on, pin, watchdog, stop set in watchdog control.
module rsr_reset_ctrl import rsr_pkg::*; #(
   parameter int PORT_W   = 8,
   parameter int WD_LONG  = WD_LONG_CNT,
   parameter int WD_SHORT = WD_SHORT_CNT,
   parameter int SYS_CYC  = SYS_CNT
) (
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Reset and wake sources
   input  wire logic              por_detect,
   input  wire logic              brownout_detect,
   input  wire logic              wdt_timeout,
   input  wire logic              watchdog_reset_select_option,
   input  wire logic              reset_pin_n,
   input  wire logic              stop_mode,
   input  wire logic              wdosc_tick,
   input  wire logic [PORT_W-1:0] port_pins_in,
   // Debug line, open drain
   input  wire logic              debug_line_pin_in,
   output logic                   debug_line_pin_out,
   output logic                   debug_line_pin_oe,
   // Reset outputs to the chip
   output logic                   core_rst,
   output logic                   periph_rst,
   output logic                   debugger_rst,
   output logic                   ctrl_defaults_load,
   output logic                   sysclk_run,
   output logic                   xtal_run,
   output logic                   vector_fetch,
   output logic [15:0]            vector_addr,
   output logic                   irq
);
   localparam int SYNC_W = SY_PORT + PORT_W;

   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic [PORT_W-1:0] port_prev;
      rsr_state_type     state;
      rsr_kind_type      kind;
      logic [7:0]        wdctl;
      logic [INT_W-1:0]  int_stat;
      logic [INT_W-1:0]  int_mask;
      logic [PORT_W-1:0] recov_en;
      logic [7:0]        dbgctl;
      logic              aw_have;
      logic [11:0]       aw_addr;
      logic              w_have;
      logic [7:0]        w_byte;
      logic              w_en;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              core_rst;
      logic              periph_rst;
      logic              debugger_rst;
      logic              ctrl_load;
      logic              sysclk_run;
      logic              xtal_run;
      logic              vector_fetch;
      logic [15:0]       vaddr;
      logic              irq;
   } rsr_main_type;

   rsr_main_type s;
   rsr_main_type n;
   rsr_kind_type go_kind;
   logic         go;
   logic         ext_f;
   logic         wdt_f;
   logic         cnt_start;
   logic         cnt_short;
   logic         cnt_wd_exp;
   logic         cnt_done;
   logic         rq_por;
   logic         rq_bo;
   logic         rq_wdt;
   logic         rq_pin;
   logic         rq_dbg;
   logic         port_edge;
   logic         sys_src;

   rsr_hold_cnt #(
      .WD_LONG  (WD_LONG),
      .WD_SHORT (WD_SHORT),
      .SYS_CYC  (SYS_CYC)
   ) u_cnt (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .start      (cnt_start),
      .short_sel  (cnt_short),
      .wd_tick    (wdosc_tick),
      .wd_expired (cnt_wd_exp),
      .done       (cnt_done)
   );

   always_comb begin
      n = s;
      n.ctrl_load    = 1'b0;
      n.vector_fetch = 1'b0;
      go        = 1'b0;
      go_kind   = KIND_SYSTEM;
      ext_f     = 1'b0;
      wdt_f     = 1'b0;
      cnt_start = 1'b0;
      cnt_short = 1'b0;
      n.sync1 = {port_pins_in, ~debug_line_pin_in, ~reset_pin_n,
                 wdt_timeout, brownout_detect, por_detect};
      n.sync2 = s.sync1;
      n.port_prev = s.sync2[SYNC_W-1:SY_PORT];
      rq_por = s.sync2[SY_POR];
      rq_bo  = s.sync2[SY_BO];
      rq_wdt = s.sync2[SY_WDT];
      rq_pin = s.sync2[SY_PIN];
      rq_dbg = s.sync2[SY_DBG];
      port_edge = |((s.sync2[SYNC_W-1:SY_PORT] ^ s.port_prev) & s.recov_en);
      // power-on wins; brown-out detector is off in stop
      sys_src = rq_por | (rq_bo & ~stop_mode);

      // Register writes
      if (s_axi_awvalid && s.awready) begin
         n.aw_have = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         n.w_have = 1'b1;
         n.w_byte = s_axi_wdata[7:0];
         n.w_en   = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (n.aw_have && n.w_have && !n.bvalid) begin
         n.aw_have = 1'b0;
         n.w_have  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = RESP_OKAY;
         if (n.aw_addr == OFF_INT_MASK) begin
            if (n.w_en) n.int_mask = n.w_byte[INT_W-1:0];
         end else if (n.aw_addr == OFF_RECOV_EN) begin
            if (n.w_en) n.recov_en = n.w_byte[PORT_W-1:0];
         end else if (n.aw_addr == OFF_DBGCTL) begin
            if (n.w_en) n.dbgctl = n.w_byte;
         end else if (n.aw_addr != OFF_WDCTL && n.aw_addr != OFF_INT_STAT) begin
            n.bresp = RESP_SLVERR;
         end
      end

      // Register reads; status clears on read
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         n.rdata  = '0;
         if (s_axi_araddr == OFF_WDCTL) begin
            n.rdata[7:0] = s.wdctl;
         end else if (s_axi_araddr == OFF_INT_STAT) begin
            n.rdata[INT_W-1:0] = s.int_stat;
            n.int_stat = '0;
         end else if (s_axi_araddr == OFF_INT_MASK) begin
            n.rdata[INT_W-1:0] = s.int_mask;
         end else if (s_axi_araddr == OFF_RECOV_EN) begin
            n.rdata[PORT_W-1:0] = s.recov_en;
         end else if (s_axi_araddr == OFF_DBGCTL) begin
            n.rdata[7:0] = s.dbgctl;
         end else begin
            n.rresp = RESP_SLVERR;
         end
      end

      // Sequencer
      case (s.state)
         ST_HOLD: begin
            // pin still low once oscillator count is over
            if (cnt_wd_exp && rq_pin) n.state = ST_PINWAIT;
            else if (cnt_done) n.state = ST_FETCH;
         end
         ST_PINWAIT: begin
            if (!rq_pin) n.state = ST_FETCH;
         end
         ST_FETCH: begin
            n.state = ST_RUN;
         end
         ST_RUN: begin
            if (stop_mode) begin
               if (rq_pin || rq_dbg) begin
                  go    = 1'b1;
                  ext_f = rq_pin;
               end else if (rq_wdt || port_edge) begin
                  go      = 1'b1;
                  go_kind = KIND_RECOVER;
               end
            end else if (s.dbgctl[DBG_RST_BIT]) begin
               go      = 1'b1;
               go_kind = KIND_DEBUG;
            end else if (rq_pin) begin
               go      = 1'b1;
               go_kind = KIND_SHORT;
               ext_f   = 1'b1;
            end else if (rq_wdt && watchdog_reset_select_option) begin
               // watchdog resets only when so selected
               go      = 1'b1;
               go_kind = KIND_SHORT;
               wdt_f   = 1'b1;
            end
         end
         default: n.state = ST_HOLD;
      endcase
      if (sys_src) begin
         go      = 1'b1;
         go_kind = KIND_SYSTEM;
         ext_f   = 1'b0;
      end

      if (go) begin
         n.state   = ST_HOLD;
         n.kind    = go_kind;
         cnt_start = 1'b1;
         cnt_short = (go_kind == KIND_SHORT);
         if (go_kind == KIND_RECOVER) begin
            n.wdctl[WDCTL_STOP] = 1'b1;
            n.wdctl[WDCTL_WDT]  = rq_wdt;
            if (rq_wdt && !watchdog_reset_select_option) n.int_stat[INT_WDT_STOP] = 1'b1;
         end else begin
            n.wdctl = WDCTL_RST;
            n.wdctl[WDCTL_POR] = sys_src;
            n.wdctl[WDCTL_EXT] = ext_f;
            n.wdctl[WDCTL_WDT] = wdt_f;
            n.int_mask  = '0;
            n.recov_en  = '0;
            n.ctrl_load = 1'b1;
            if (go_kind == KIND_DEBUG) n.dbgctl[DBG_RST_BIT] = 1'b0;
            else n.dbgctl = '0;
         end
      end

      if (n.state == ST_FETCH && s.state != ST_FETCH) begin
         n.vector_fetch = 1'b1;
         n.int_stat[INT_RELEASE] = 1'b1;
         if (s.kind == KIND_RECOVER) n.int_stat[INT_RECOVERY] = 1'b1;
      end

      n.core_rst     = (n.state == ST_HOLD) || (n.state == ST_PINWAIT);
      n.periph_rst   = n.core_rst;
      n.debugger_rst = n.core_rst && (n.kind == KIND_SYSTEM || n.kind == KIND_SHORT);
      n.xtal_run     = n.core_rst || !stop_mode;
      if (n.state == ST_HOLD) n.sysclk_run = cnt_wd_exp && !cnt_start;
      else if (n.state == ST_PINWAIT) n.sysclk_run = 1'b1;
      else n.sysclk_run = !stop_mode;
      n.irq     = |(n.int_stat & n.int_mask);
      n.awready = !n.aw_have && !n.bvalid;
      n.wready  = !n.w_have && !n.bvalid;
      n.arready = !n.rvalid;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s              <= '0;
         s.state        <= ST_HOLD;
         s.kind         <= KIND_SYSTEM;
         s.wdctl        <= WDCTL_POR_INIT;
         s.core_rst     <= 1'b1;
         s.periph_rst   <= 1'b1;
         s.debugger_rst <= 1'b1;
         s.xtal_run     <= 1'b1;
         s.vaddr        <= RESET_VEC_ADDR;
         s.awready      <= 1'b1;
         s.wready       <= 1'b1;
         s.arready      <= 1'b1;
      end else if (ce) begin
         s <= n;
      end
   end

   assign s_axi_awready      = s.awready;
   assign s_axi_wready       = s.wready;
   assign s_axi_bresp        = s.bresp;
   assign s_axi_bvalid       = s.bvalid;
   assign s_axi_arready      = s.arready;
   assign s_axi_rdata        = s.rdata;
   assign s_axi_rresp        = s.rresp;
   assign s_axi_rvalid       = s.rvalid;
   assign debug_line_pin_out = 1'b0;
   assign debug_line_pin_oe  = 1'b0;
   assign core_rst           = s.core_rst;
   assign periph_rst         = s.periph_rst;
   assign debugger_rst       = s.debugger_rst;
   assign ctrl_defaults_load = s.ctrl_load;
   assign sysclk_run         = s.sysclk_run;
   assign xtal_run           = s.xtal_run;
   assign vector_fetch       = s.vector_fetch;
   assign vector_addr        = s.vaddr;
   assign irq                = s.irq;

   sequence rst_begins;
      $rose(s.core_rst);
   endsequence

   a_por_system: assert property (@(posedge clk) disable iff (rst || !ce)
      sys_src |=> s.state == ST_HOLD && s.kind == KIND_SYSTEM && s.wdctl[WDCTL_POR])
      else $error("power-on did not start a system reset");
   a_pin_short: assert property (@(posedge clk) disable iff (rst || !ce)
      s.state == ST_RUN && !stop_mode && rq_pin && !sys_src && !s.dbgctl[DBG_RST_BIT]
      |=> s.kind == KIND_SHORT && s.wdctl[WDCTL_EXT] && s.core_rst)
      else $error("reset pin did not give short reset");
   a_wdt_option: assert property (@(posedge clk) disable iff (rst || !ce)
      s.state == ST_RUN && !stop_mode && rq_wdt && !watchdog_reset_select_option
      && !rq_pin && !sys_src && !s.dbgctl[DBG_RST_BIT] |=> !s.core_rst)
      else $error("watchdog reset while interrupt selected");
   a_stop_wake: assert property (@(posedge clk) disable iff (rst || !ce)
      s.state == ST_RUN && stop_mode && (rq_wdt || port_edge) && !rq_pin && !rq_dbg
      && !sys_src |=> s.kind == KIND_RECOVER && s.wdctl[WDCTL_STOP] && s.core_rst)
      else $error("stop wake did not start recovery");
   a_recover_keeps: assert property (@(posedge clk) disable iff (rst || !ce)
      rst_begins and s.kind == KIND_RECOVER |-> $stable(s.int_mask) && !s.ctrl_load)
      else $error("recovery disturbed control registers");
   a_defaults_load: assert property (@(posedge clk) disable iff (rst || !ce)
      rst_begins and s.kind != KIND_RECOVER |-> s.ctrl_load && s.int_mask == '0)
      else $error("defaults not loaded on reset");
   a_fetch_vector: assert property (@(posedge clk) disable iff (rst || !ce)
      $fell(s.core_rst) |-> s.vector_fetch && s.vaddr == RESET_VEC_ADDR ##1 !s.vector_fetch)
      else $error("no vector fetch at release");
   a_osc_running: assert property (@(posedge clk) disable iff (rst || !ce)
      s.core_rst |-> s.xtal_run && s.periph_rst)
      else $error("oscillator or peripherals not held");
   a_clock_late: assert property (@(posedge clk) disable iff (rst || !ce)
      $rose(s.sysclk_run) && s.state == ST_HOLD |-> $past(cnt_wd_exp))
      else $error("system clock before oscillator count");
   a_pin_release: assert property (@(posedge clk) disable iff (rst || !ce)
      s.state == ST_PINWAIT && !rq_pin |=> s.vector_fetch && !s.core_rst)
      else $error("no immediate exit after pin release");
endmodule
`default_nettype wire

// File: test/rsr_far_model.sv
// Far-side model: watchdog oscillator, reset pin, debug line, core fetch
`timescale 1ns/1ps
`default_nettype none
module rsr_far_model #(
   parameter int TICK_DIV = 4
) (
   // Clock
   input  wire logic        clk,
   // Bench requests to pull pins low
   input  wire logic        pin_req,
   input  wire logic        dbg_req,
   // Block pins
   input  wire logic        debug_line_pin_out,
   input  wire logic        debug_line_pin_oe,
   output logic             debug_line_pin_in,
   output logic             reset_pin_n,
   output logic             wdosc_tick,
   // Core side
   input  wire logic        vector_fetch,
   input  wire logic [15:0] vector_addr,
   output logic [15:0]      fetch_addr,
   output int               fetches
);
   int div = 0;
   initial begin
      wdosc_tick = 1'b0;
      fetches = 0;
      fetch_addr = 16'hFFFF;
   end
   always @(posedge clk) begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      wdosc_tick <= (div == TICK_DIV - 1);
   end
   assign reset_pin_n = !pin_req;
   // Open drain with pull-up, either party may pull low
   assign debug_line_pin_in = !(dbg_req || (debug_line_pin_oe && !debug_line_pin_out));
   always @(posedge clk) begin
      if (vector_fetch) begin
         fetches <= fetches + 1;
         fetch_addr <= vector_addr;
      end
   end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the reset and stop-recovery controller
`timescale 1ns/1ps
`default_nettype none
module testbench import rsr_pkg::*;;
   logic        clk = 1'b0, rst = 1'b1, stop_mode = 1'b0, por_detect = 1'b0, brownout_detect = 1'b0;
   logic        wdt_timeout = 1'b0, watchdog_reset_select_option = 1'b0, pin_req = 1'b0, dbg_req = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [7:0]  port_pins_in = 8'h00;
   logic [15:0] vector_addr, fetch_addr;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdosc_tick, reset_pin_n;
   logic        debug_line_pin_in, debug_line_pin_out, debug_line_pin_oe, core_rst, periph_rst, debugger_rst;
   logic        ctrl_defaults_load, sysclk_run, xtal_run, vector_fetch, irq;
   int          errors = 0, num_checks = 0, cyc = 0, loads = 0, drst = 0, fetches, l0, d0;

   rsr_reset_ctrl u_rsr_reset_ctrl (
      .clk, .rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .por_detect, .brownout_detect,
      .wdt_timeout, .watchdog_reset_select_option, .reset_pin_n, .stop_mode, .wdosc_tick, .port_pins_in,
      .debug_line_pin_in, .debug_line_pin_out, .debug_line_pin_oe, .core_rst, .periph_rst, .debugger_rst,
      .ctrl_defaults_load, .sysclk_run, .xtal_run, .vector_fetch, .vector_addr, .irq
   );
   rsr_far_model u_rsr_far_model (
      .clk, .pin_req, .dbg_req, .debug_line_pin_out, .debug_line_pin_oe, .debug_line_pin_in, .reset_pin_n,
      .wdosc_tick, .vector_fetch, .vector_addr, .fetch_addr, .fetches
   );

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic give_verdict();
      if (errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Cycle ceiling, pulse and level monitors
   always @(posedge clk) begin
      cyc <= cyc + 1;
      loads <= loads + int'(ctrl_defaults_load);
      drst <= drst + int'(debugger_rst);
      if (cyc == 30000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %0h got %0h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk(nm, s_axi_rdata, e);
      chk(nm, 32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
   endtask

   // Waits for one hold and measures both phases
   task automatic hold(input int n, input string nm);
      int t;
      int c;
      t = 0;
      c = 0;
      while (core_rst !== 1'b1) @(posedge clk);
      @(posedge clk);
      chk({nm, " xtal"}, 32'(xtal_run & periph_rst), 32'h1);
      while (sysclk_run !== 1'b1) begin
         @(posedge clk);
         t += int'(wdosc_tick);
      end
      while (core_rst !== 1'b0) begin
         @(posedge clk);
         c++;
      end
      chk({nm, " ticks"}, 32'(t >= n - 1 && t <= n + 1), 32'h1);
      chk({nm, " clocks"}, 32'(c >= SYS_CNT && c <= SYS_CNT + 3), 32'h1);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      hold(WD_LONG_CNT, "por");
      rdchk("cause", OFF_WDCTL, 32'h80, RESP_OKAY);
      chk("vector", 32'(fetch_addr), 32'h2);
      wr(OFF_INT_MASK, 32'h7, r);
      @(posedge clk);
      chk("irq", 32'(irq), 32'h1);
      rdchk("stat", OFF_INT_STAT, 32'h1, RESP_OKAY);
      rdchk("stat", OFF_INT_STAT, 32'h0, RESP_OKAY);
      chk("irq", 32'(irq), 32'h0);
      rdchk("unmapped", 12'h010, 32'h0, RESP_SLVERR);
      wr(OFF_WDCTL, 32'h0, r);
      chk("wresp", 32'(r), 32'(RESP_OKAY));
      rdchk("cause", OFF_WDCTL, 32'h80, RESP_OKAY);
      l0 = loads;
      d0 = drst;
      pin_req <= 1'b1;
      repeat (3) @(posedge clk);
      pin_req <= 1'b0;
      hold(WD_SHORT_CNT, "pin");
      chk("loads", 32'(loads - l0), 32'h1);
      chk("dbg rst", 32'(drst > d0), 32'h1);
      rdchk("cause", OFF_WDCTL, 32'h10, RESP_OKAY);
      rdchk("mask", OFF_INT_MASK, 32'h0, RESP_OKAY);
      wdt_timeout <= 1'b1;
      @(posedge clk);
      wdt_timeout <= 1'b0;
      repeat (10) @(posedge clk);
      chk("wdt irq opt", 32'(core_rst), 32'h0);
      watchdog_reset_select_option <= 1'b1;
      wdt_timeout <= 1'b1;
      @(posedge clk);
      wdt_timeout <= 1'b0;
      hold(WD_SHORT_CNT, "wdt");
      rdchk("cause", OFF_WDCTL, 32'h20, RESP_OKAY);
      pin_req <= 1'b1;
      repeat (WD_SHORT_CNT * 4 + 100) @(posedge clk);
      chk("pin held", 32'(core_rst), 32'h1);
      pin_req <= 1'b0;
      repeat (8) @(posedge clk);
      chk("pin free", 32'(core_rst), 32'h0);
      wr(OFF_RECOV_EN, 32'h1, r);
      wr(OFF_INT_MASK, 32'h2, r);
      l0 = loads;
      stop_mode <= 1'b1;
      port_pins_in <= 8'h02;
      repeat (10) @(posedge clk);
      chk("port off", 32'(core_rst), 32'h0);
      port_pins_in <= 8'h03;
      repeat (4) @(posedge clk);
      stop_mode <= 1'b0;
      hold(WD_LONG_CNT, "recov");
      chk("loads", 32'(loads - l0), 32'h0);
      rdchk("cause", OFF_WDCTL, 32'h50, RESP_OKAY);
      rdchk("mask", OFF_INT_MASK, 32'h2, RESP_OKAY);
      stop_mode <= 1'b1;
      brownout_detect <= 1'b1;
      repeat (10) @(posedge clk);
      chk("bo stop", 32'(core_rst), 32'h0);
      brownout_detect <= 1'b0;
      dbg_req <= 1'b1;
      repeat (4) @(posedge clk);
      stop_mode <= 1'b0;
      dbg_req <= 1'b0;
      hold(WD_LONG_CNT, "dbg pin");
      rdchk("mask", OFF_INT_MASK, 32'h0, RESP_OKAY);
      d0 = drst;
      wr(OFF_DBGCTL, 32'h2, r);
      hold(WD_LONG_CNT, "dbg cmd");
      chk("dbg spared", 32'(drst - d0), 32'h0);
      rdchk("dbgctl", OFF_DBGCTL, 32'h0, RESP_OKAY);
      watchdog_reset_select_option <= 1'b0;
      stop_mode <= 1'b1;
      wdt_timeout <= 1'b1;
      repeat (4) @(posedge clk);
      stop_mode <= 1'b0;
      wdt_timeout <= 1'b0;
      hold(WD_LONG_CNT, "wdt stop");
      rdchk("cause", OFF_WDCTL, 32'h60, RESP_OKAY);
      pin_req <= 1'b1;
      repeat (20) @(posedge clk);
      por_detect <= 1'b1;
      repeat (4) @(posedge clk);
      por_detect <= 1'b0;
      pin_req <= 1'b0;
      hold(WD_LONG_CNT, "por win");
      rdchk("cause", OFF_WDCTL, 32'h80, RESP_OKAY);
      chk("fetches", 32'(fetches), 32'h9);
      give_verdict();
   end
endmodule
`default_nettype wire
